/* hw/audio_ctrl_pkg.sv */
package audio_ctrl_pkg;

    // register byte addresses on the system bus
    localparam logic [31:0] SUBBLOCK_RESET_ADDR = 32'hFFF0_9004;
    localparam logic [31:0] REC_BASE_ADDR = 32'hFFF0_9008;
    localparam logic [31:0] REC_LENGTH_ADDR = 32'hFFF0_900C;
    localparam logic [31:0] REC_CURRENT_ADDR = 32'hFFF0_9010;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'hFFF0_9050;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hFFF0_9054;

    // reset values
    localparam logic [31:0] SUBBLOCK_RESET_RST = 32'h0000_0000;
    localparam logic [31:0] REC_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] REC_LENGTH_RST = 32'h0000_0000;
    localparam logic [31:0] REC_CURRENT_RST = 32'h0000_0000;
    localparam logic [1:0] IRQ_STATUS_RST = 2'h0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    // field positions in the sub-block reset control register
    localparam int GLOBAL_RESET_BIT = 16;
    localparam int REC_CHAN_HI = 15;
    localparam int REC_CHAN_LO = 14;
    localparam int PLAY_CHAN_HI = 13;
    localparam int PLAY_CHAN_LO = 12;
    localparam int ACL_RECORD_BIT = 8;
    localparam int ACL_PLAY_BIT = 7;
    localparam int I2S_RECORD_BIT = 6;
    localparam int I2S_PLAY_BIT = 5;
    localparam int ACL_RESET_BIT = 1;
    localparam int I2S_RESET_BIT = 0;
    localparam logic [31:0] SUBBLOCK_RESET_WMASK = 32'h0001_F1E3;

    // interrupt status and mask layout
    localparam int IRQ_MID_BIT = 0;
    localparam int IRQ_END_BIT = 1;

    // channel mode codes
    localparam logic [1:0] REC_DUAL = 2'h3;
    localparam logic [1:0] REC_LEFT = 2'h1;
    localparam logic [1:0] REC_RIGHT = 2'h2;
    localparam logic [1:0] PLAY_STEREO = 2'h3;
    localparam logic [1:0] PLAY_MONO = 2'h2;

    // bytes stored per recorded sample
    localparam logic [31:0] SAMPLE_BYTES = 32'h0000_0004;

    // ahb-lite transfer codes
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // bus slave states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WRITE = 4'h2,
        ST_RWAIT = 4'h4,
        ST_RDONE = 4'h8
    } bus_state_e;

    // one stored record sample heading for memory
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } dma_write_s;

endpackage : audio_ctrl_pkg

/* hw/audio_path_reset_record_dma_regs.sv */
// Operation
// - the sub-block reset control register is a 32-bit read/write word at its address, zero after reset.
// - bit 16 set holds the whole audio controller in reset, cleared returns it to normal work.
// - bits 15:14 choose the record channels: 11 dual, 01 left only, 10 right only, 00 reserved.
// - when the converter is the record path only the left channel is recorded, whatever is requested.
// - bits 13:12 choose playback: 11 stereo, 10 mono, 00 and 01 reserved.
// - bit 8 enables the AC-link record path.
// - bit 7 enables the AC-link playback path.
// - bit 6 enables the I2S record path.
// - bit 5 enables the I2S playback path.
// - bit 1 holds the AC-link sub-block in reset while set.
// - bit 0 holds the I2S sub-block in reset while set.
// - the record base register holds a 32-bit address, read/write, only the processor changes it, zero at reset.
// - the record length register holds a 32-bit length, read/write, only the processor changes it, zero at reset.
// - the record interrupt flag sets when the current address reaches middle or end, clears by writing one, and drives an inverted request.
// - the record current address is a 32-bit register that the processor can only read.
`timescale 1ns/1ps
`default_nettype none

module audio_path_reset_record_dma_regs
    import audio_ctrl_pkg::*;
(
    input wire logic clk_in, // 100 MHz system clock
    input wire logic reset_in, // synchronous, active high
    input wire logic hsel_in, // ahb slave select
    input wire logic [31:0] haddr_in, // ahb address
    input wire logic [1:0] htrans_in, // ahb transfer type
    input wire logic hwrite_in, // ahb write
    input wire logic [2:0] hsize_in, // ahb size, word only
    input wire logic [31:0] hwdata_in, // ahb write data
    input wire logic hready_in, // ahb bus ready
    output logic [31:0] hrdata_out, // ahb read data
    output logic hreadyout_out, // ahb slave ready
    output logic hresp_out, // ahb response, always okay
    input wire logic adc_record_sel_in, // converter chosen as record path
    input wire logic sample_valid_in, // record sample offered
    input wire logic [31:0] sample_data_in, // record sample
    output logic sample_ready_out, // record sample accepted
    output logic dma_wr_valid_out, // memory write request pulse
    output dma_write_s dma_wr_out, // memory write address and data
    output logic audio_global_reset_out, // whole controller reset
    output logic i2s_reset_out, // i2s sub-block reset
    output logic acl_subblock_reset_out, // ac-link sub-block reset
    output logic i2s_play_en_out, // i2s playback path enable
    output logic i2s_record_en_out, // i2s record path enable
    output logic acl_playback_enable_out, // ac-link playback path enable
    output logic acl_record_enable_out, // ac-link record path enable
    output logic [1:0] rec_chan_mode_out, // effective record channels
    output logic [1:0] play_chan_mode_out, // playback channel mode
    output logic rec_irq_n_out, // record dma request, active low
    output logic irq_out // masked interrupt, active high
);

    // bus slave state
    bus_state_e state_reg;
    bus_state_e state_next;
    logic [31:0] addr_reg;
    logic [31:0] hrdata_reg;

    // software-visible registers
    logic [31:0] ctrl_reg;
    logic [31:0] base_reg;
    logic [31:0] length_reg;
    logic [31:0] current_reg;
    logic [31:0] current_next;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic dma_valid_reg;
    dma_write_s dma_wr_reg;

    // address phase capture and data phase write decode
    wire logic accept = hsel_in && htrans_in[1] && hready_in;
    wire logic wr_phase = (state_reg == ST_WRITE);
    wire logic wr_ctrl = wr_phase && (addr_reg == SUBBLOCK_RESET_ADDR);
    wire logic wr_base = wr_phase && (addr_reg == REC_BASE_ADDR);
    wire logic wr_length = wr_phase && (addr_reg == REC_LENGTH_ADDR);
    wire logic wr_status = wr_phase && (addr_reg == IRQ_STATUS_ADDR);
    wire logic wr_mask = wr_phase && (addr_reg == IRQ_MASK_ADDR);

    // read selection; unmapped words read zero
    wire logic [31:0] rd_mux =
        (addr_reg == SUBBLOCK_RESET_ADDR) ? ctrl_reg :
        (addr_reg == REC_BASE_ADDR) ? base_reg :
        (addr_reg == REC_LENGTH_ADDR) ? length_reg :
        (addr_reg == REC_CURRENT_ADDR) ? current_reg :
        (addr_reg == IRQ_STATUS_ADDR) ? {30'h0000_0000, status_reg} :
        (addr_reg == IRQ_MASK_ADDR) ? {30'h0000_0000, mask_reg} : 32'h0000_0000;

    // bus state sequencing; reads take one wait state so hrdata comes from a flop
    always_comb
    begin
        case (state_reg)
            ST_IDLE, ST_WRITE, ST_RDONE:
            begin
                if (accept)
                    state_next = hwrite_in ? ST_WRITE : ST_RWAIT;
                else
                    state_next = ST_IDLE;
            end
            ST_RWAIT: state_next = ST_RDONE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_reg <= ST_IDLE;
            addr_reg <= 32'h0000_0000;
            hrdata_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            if (accept)
                addr_reg <= haddr_in;
            if (state_reg == ST_RWAIT)
                hrdata_reg <= rd_mux;
        end
    end

    assign hrdata_out = hrdata_reg;
    assign hreadyout_out = (state_reg != ST_RWAIT);
    assign hresp_out = HRESP_OKAY;

    // control word; reserved bits stay zero because the write mask drops them
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            ctrl_reg <= SUBBLOCK_RESET_RST;
        else if (wr_ctrl)
            ctrl_reg <= hwdata_in & SUBBLOCK_RESET_WMASK;
    end

    // dma base and length are written only from the bus, never by the engine
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            base_reg <= REC_BASE_RST;
            length_reg <= REC_LENGTH_RST;
            mask_reg <= IRQ_MASK_RST;
        end
        else
        begin
            if (wr_base)
                base_reg <= hwdata_in;
            if (wr_length)
                length_reg <= hwdata_in;
            if (wr_mask)
                mask_reg <= hwdata_in[1:0];
        end
    end

    assign audio_global_reset_out = ctrl_reg[GLOBAL_RESET_BIT];
    assign i2s_reset_out = ctrl_reg[I2S_RESET_BIT] | ctrl_reg[GLOBAL_RESET_BIT];
    assign acl_subblock_reset_out = ctrl_reg[ACL_RESET_BIT] | ctrl_reg[GLOBAL_RESET_BIT];
    assign i2s_play_en_out = ctrl_reg[I2S_PLAY_BIT] & ~ctrl_reg[GLOBAL_RESET_BIT];
    assign i2s_record_en_out = ctrl_reg[I2S_RECORD_BIT] & ~ctrl_reg[GLOBAL_RESET_BIT];
    assign acl_playback_enable_out = ctrl_reg[ACL_PLAY_BIT] & ~ctrl_reg[GLOBAL_RESET_BIT];
    assign acl_record_enable_out = ctrl_reg[ACL_RECORD_BIT] & ~ctrl_reg[GLOBAL_RESET_BIT];
    // converter forces left only; reserved code passes through unchanged
    assign rec_chan_mode_out = adc_record_sel_in ? REC_LEFT : ctrl_reg[REC_CHAN_HI:REC_CHAN_LO];
    // playback mode straight from the field
    assign play_chan_mode_out = ctrl_reg[PLAY_CHAN_HI:PLAY_CHAN_LO];

    // record engine address arithmetic; middle is base plus half the length
    // both enables are already gated by global reset, so no extra term is needed here
    wire logic rec_en = acl_record_enable_out | i2s_record_en_out;
    wire logic fire = sample_valid_in & rec_en;
    wire logic [31:0] end_addr = base_reg + length_reg;
    wire logic [31:0] mid_addr = base_reg + {1'b0, length_reg[31:1]};
    wire logic [31:0] step_addr = current_reg + SAMPLE_BYTES;
    wire logic hit_end = fire && (step_addr >= end_addr);
    wire logic hit_mid = fire && (current_reg < mid_addr) && (step_addr >= mid_addr) && !hit_end;

    assign sample_ready_out = rec_en;

    // start at base, advance, wrap at base plus length
    always_comb
    begin
        if (!rec_en)
            current_next = base_reg;
        else if (hit_end)
            current_next = base_reg;
        else if (fire)
            current_next = step_addr;
        else
            current_next = current_reg;
    end

    // current address kept by hardware only
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            current_reg <= REC_CURRENT_RST;
        else
            current_reg <= current_next;
    end

    // sample write request; data registered so memory sees stable words
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            dma_valid_reg <= 1'b0;
            dma_wr_reg <= '0;
        end
        else
        begin
            dma_valid_reg <= fire;
            if (fire)
            begin
                dma_wr_reg.addr <= current_reg;
                dma_wr_reg.data <= sample_data_in;
            end
        end
    end

    assign dma_wr_valid_out = dma_valid_reg;
    assign dma_wr_out = dma_wr_reg;

    // sticky flags, write one clears, a new event wins over the clear
    wire logic [1:0] status_set = {hit_end, hit_mid};
    wire logic [1:0] status_clr = wr_status ? hwdata_in[1:0] : 2'h0;
    assign status_next = (status_reg & ~status_clr) | status_set;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            status_reg <= IRQ_STATUS_RST;
        else
            status_reg <= status_next;
    end

    // inverted request follows any record flag
    assign rec_irq_n_out = ~(status_reg[IRQ_MID_BIT] | status_reg[IRQ_END_BIT]);
    assign irq_out = |(status_reg & mask_reg);

    // checks on the design's own outputs and internal registers
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    logic rd_ctrl_ph;
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            rd_ctrl_ph <= 1'b0;
        else
            rd_ctrl_ph <= accept && !hwrite_in && (haddr_in == SUBBLOCK_RESET_ADDR);
    end

    chk_ctrl_readback: assert property (
        rd_ctrl_ph |=> hreadyout_out && (hrdata_out == $past(ctrl_reg)))
        else $error("control word read back wrong");

    chk_global_reset_hold: assert property (
        audio_global_reset_out |-> i2s_reset_out && acl_subblock_reset_out
            && !sample_ready_out && !i2s_play_en_out && !acl_playback_enable_out)
        else $error("global reset does not hold the paths");

    chk_rec_chan_mode: assert property (
        !adc_record_sel_in |-> rec_chan_mode_out == ctrl_reg[REC_CHAN_HI:REC_CHAN_LO])
        else $error("record channel mode wrong");

    chk_adc_left_only: assert property (
        adc_record_sel_in |-> rec_chan_mode_out == REC_LEFT)
        else $error("converter path not left only");

    chk_play_chan_mode: assert property (
        wr_ctrl |=> play_chan_mode_out == $past(hwdata_in[PLAY_CHAN_HI:PLAY_CHAN_LO]))
        else $error("playback mode not taken from write");

    chk_acl_rec_enable: assert property (
        wr_ctrl && !hwdata_in[GLOBAL_RESET_BIT]
            |=> acl_record_enable_out == $past(hwdata_in[ACL_RECORD_BIT]))
        else $error("ac-link record enable wrong");

    chk_acl_play_enable: assert property (
        wr_ctrl && !hwdata_in[GLOBAL_RESET_BIT]
            |=> acl_playback_enable_out == $past(hwdata_in[ACL_PLAY_BIT]))
        else $error("ac-link playback enable wrong");

    chk_i2s_rec_enable: assert property (
        wr_ctrl && !hwdata_in[GLOBAL_RESET_BIT]
            |=> i2s_record_en_out == $past(hwdata_in[I2S_RECORD_BIT]))
        else $error("i2s record enable wrong");

    chk_i2s_play_enable: assert property (
        wr_ctrl && !hwdata_in[GLOBAL_RESET_BIT]
            |=> i2s_play_en_out == $past(hwdata_in[I2S_PLAY_BIT]))
        else $error("i2s playback enable wrong");

    chk_acl_reset_bit: assert property (
        wr_ctrl && hwdata_in[ACL_RESET_BIT] |=> acl_subblock_reset_out)
        else $error("ac-link reset not applied");

    chk_i2s_reset_bit: assert property (
        wr_ctrl && hwdata_in[I2S_RESET_BIT] |=> i2s_reset_out)
        else $error("i2s reset not applied");

    chk_base_stable: assert property (
        !wr_base |=> $stable(base_reg))
        else $error("base changed without a write");

    chk_length_write: assert property (
        wr_length |=> length_reg == $past(hwdata_in))
        else $error("length not written");

    chk_end_flag: assert property (
        hit_end |=> status_reg[IRQ_END_BIT] && !rec_irq_n_out)
        else $error("end event lost");

    chk_mid_flag: assert property (
        hit_mid |=> status_reg[IRQ_MID_BIT] && !rec_irq_n_out)
        else $error("middle event lost");

    chk_current_ro: assert property (
        wr_phase && !fire && rec_en && $stable(rec_en) |=> $stable(current_reg))
        else $error("current address written by bus");

    chk_dma_wrap: assert property (
        hit_end && !wr_base |=> current_reg == $past(base_reg) ##1 1'b1)
        else $error("record address did not wrap");

    cov_read_ctrl: cover property (rd_ctrl_ph ##1 hreadyout_out);
    cov_mid_then_end: cover property (hit_mid ##[1:50] hit_end);
    cov_irq_clear: cover property (irq_out ##1 wr_status ##1 !irq_out);
    cov_global_reset: cover property (audio_global_reset_out ##1 !audio_global_reset_out);

endmodule : audio_path_reset_record_dma_regs

`default_nettype wire

/* tb/codec_sample_source.sv */
`timescale 1ns/1ps
`default_nettype none

// stand-in for the codec side: offers record samples, optionally with idle gaps
module codec_sample_source (
    input wire logic clk_in, // system clock
    input wire logic reset_in, // synchronous, active high
    input wire logic run_in, // offer samples while high
    input wire logic slow_in, // leave idle cycles between samples
    input wire logic [7:0] samples_in, // number of samples to offer
    input wire logic ready_in, // block takes the sample
    output logic valid_out, // sample offered
    output logic [31:0] data_out // sample value
);
    logic valid_reg;
    logic tick_reg;
    logic [7:0] sent_reg;
    logic [31:0] value_reg;
    logic take;
    logic want;

    // an offered sample is held until taken, never withdrawn early
    assign take = valid_reg && ready_in;
    assign want = run_in && !(slow_in && tick_reg);
    // a released data line shows the inverse, so a stale value never looks right
    assign valid_out = valid_reg;
    assign data_out = valid_reg ? value_reg : ~value_reg;

    // offer sequencing, one sample per transfer
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            valid_reg <= 1'b0;
            tick_reg <= 1'b0;
            sent_reg <= 8'h00;
            value_reg <= 32'hA5A5_0000;
        end
        else
        begin
            tick_reg <= ~tick_reg;
            if (take)
            begin
                sent_reg <= sent_reg + 8'h01;
                value_reg <= value_reg + 32'h0000_0001;
                valid_reg <= want && ((sent_reg + 8'h01) < samples_in);
            end
            else if (!valid_reg)
                valid_reg <= want && (sent_reg < samples_in);
        end
    end
endmodule : codec_sample_source

`default_nettype wire

/* tb/test_audio_path_reset_record_dma_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// compare two values, count it, report a mismatch at once
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module test_audio_path_reset_record_dma_regs
    import audio_ctrl_pkg::*;
;
    logic clk, rst, hsel, hwrite, hready, hresp, adc_sel, run, slow;
    logic s_valid, s_ready, dma_valid, glob_rst, i2s_rst, acl_rst;
    logic i2s_play, i2s_rec, acl_play, acl_rec, rec_irq_n, irq;
    logic [1:0] htrans, rec_mode, play_mode;
    logic [31:0] haddr, hwdata, hrdata, s_data, rd;
    dma_write_s dma_wr;
    dma_write_s got_q[$];
    int num_errors = 0;
    int comparisons = 0;

    always #5 clk = ~clk;

    // hready is the one slave's hreadyout; only whole words are sent
    audio_path_reset_record_dma_regs u_audio_path_reset_record_dma_regs (
        .clk_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .adc_record_sel_in(adc_sel), .sample_valid_in(s_valid), .sample_data_in(s_data),
        .sample_ready_out(s_ready), .dma_wr_valid_out(dma_valid), .dma_wr_out(dma_wr),
        .audio_global_reset_out(glob_rst), .i2s_reset_out(i2s_rst),
        .acl_subblock_reset_out(acl_rst), .i2s_play_en_out(i2s_play),
        .i2s_record_en_out(i2s_rec), .acl_playback_enable_out(acl_play),
        .acl_record_enable_out(acl_rec), .rec_chan_mode_out(rec_mode),
        .play_chan_mode_out(play_mode), .rec_irq_n_out(rec_irq_n), .irq_out(irq));

    codec_sample_source u_codec_sample_source (
        .clk_in(clk), .reset_in(rst), .run_in(run), .slow_in(slow), .samples_in(8'h05),
        .ready_in(s_ready), .valid_out(s_valid), .data_out(s_data));

    // memory writes are collected mid-cycle, where the registered pulse is settled
    always @(negedge clk)
        if (dma_valid === 1'b1)
            got_q.push_back(dma_wr);

    task automatic test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // ready is looked at mid-cycle; it cannot change before the next rising edge
    task automatic wait_ready(output logic [31:0] data);
        logic seen;
        seen = 1'b0;
        for (int n = 0; !seen; n++)
        begin
            if (n > 50)
            begin
                num_errors++;
                test_done();
            end
            @(negedge clk);
            seen = (hready === 1'b1);
            data = hrdata;
            @(posedge clk);
        end
    endtask : wait_ready

    task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata);
        logic [31:0] dummy;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready(dummy);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wdata;
        wait_ready(rdata);
    endtask : bus_xfer

    task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        bus_xfer(1'b1, addr, data, unused);
    endtask : bus_write

    task automatic bus_read(input logic [31:0] addr, input logic [31:0] exp);
        bus_xfer(1'b0, addr, 32'h0000_0000, rd);
        `CHECK(rd, exp)
    endtask : bus_read

    // one control word: every path output and the read-back follow its bits
    task automatic ctrl_case(input logic [31:0] v);
        logic g;
        g = v[16];
        bus_write(SUBBLOCK_RESET_ADDR, v);
        @(negedge clk);
        `CHECK(glob_rst, g)
        `CHECK(i2s_rst, v[0] | g)
        `CHECK(acl_rst, v[1] | g)
        `CHECK(i2s_play, v[5] & ~g)
        `CHECK(i2s_rec, v[6] & ~g)
        `CHECK(acl_play, v[7] & ~g)
        `CHECK(acl_rec, v[8] & ~g)
        `CHECK(rec_mode, (adc_sel ? REC_LEFT : v[15:14]))
        `CHECK(play_mode, v[13:12])
        bus_read(SUBBLOCK_RESET_ADDR, v & SUBBLOCK_RESET_WMASK);
    endtask : ctrl_case

    task automatic test_reset_state();
        `CHECK({hready, hresp, rec_irq_n, irq, s_ready}, 5'b10100)
        bus_read(SUBBLOCK_RESET_ADDR, 32'h0000_0000);
        bus_read(REC_BASE_ADDR, 32'h0000_0000);
        bus_read(REC_LENGTH_ADDR, 32'h0000_0000);
        bus_read(REC_CURRENT_ADDR, 32'h0000_0000);
    endtask : test_reset_state

    // all channel codes, every enable and reset bit, global reset, reserved bits
    task automatic test_ctrl_fields();
        logic [31:0] tbl [7] = '{32'h0000_C021, 32'h0000_6042, 32'h0000_8080, 32'h0000_1100,
                                 32'h0001_F1E3, 32'hFFFE_0000, 32'h0000_0000};
        for (int a = 0; a < 2; a++)
        begin
            @(posedge clk);
            adc_sel <= a[0];
            foreach (tbl[i])
                ctrl_case(tbl[i]);
        end
        @(posedge clk);
        adc_sel <= 1'b0;
    endtask : test_ctrl_fields

    // full-width storage, read-only current address, unmapped place
    task automatic test_data_regs();
        bus_write(REC_BASE_ADDR, 32'hFFFF_FFFC);
        bus_write(REC_LENGTH_ADDR, 32'h8765_4320);
        bus_write(REC_CURRENT_ADDR, 32'h1234_5678);
        bus_write(32'hFFF0_9080, 32'h0000_0001);
        bus_read(REC_BASE_ADDR, 32'hFFFF_FFFC);
        bus_read(REC_LENGTH_ADDR, 32'h8765_4320);
        bus_read(REC_CURRENT_ADDR, 32'hFFFF_FFFC);
        bus_read(32'hFFF0_9080, 32'h0000_0000);
    endtask : test_data_regs

    // five spaced-out samples through a 16-byte ring: middle, end and wrap
    task automatic test_record();
        bus_write(REC_BASE_ADDR, 32'h0000_1000);
        bus_write(REC_LENGTH_ADDR, 32'h0000_0010);
        bus_write(IRQ_MASK_ADDR, 32'h0000_0003);
        bus_write(SUBBLOCK_RESET_ADDR, 32'h0000_C040);
        @(posedge clk);
        run <= 1'b1;
        slow <= 1'b1;
        for (int n = 0; got_q.size() < 5; n++)
        begin
            if (n > 200)
            begin
                num_errors++;
                test_done();
            end
            @(posedge clk);
        end
        run <= 1'b0;
        foreach (got_q[i])
        begin
            `CHECK(got_q[i].addr, 32'h0000_1000 + 32'(4 * (i % 4)))
            `CHECK(got_q[i].data, 32'hA5A5_0000 + 32'(i))
        end
        bus_read(REC_CURRENT_ADDR, 32'h0000_1004);
        bus_read(IRQ_STATUS_ADDR, 32'h0000_0003);
        `CHECK({rec_irq_n, irq}, 2'b01)
        bus_write(IRQ_MASK_ADDR, 32'h0000_0000);
        @(negedge clk);
        `CHECK({rec_irq_n, irq}, 2'b00)
        bus_write(IRQ_STATUS_ADDR, 32'h0000_0001);
        bus_read(IRQ_STATUS_ADDR, 32'h0000_0002);
        bus_write(IRQ_STATUS_ADDR, 32'h0000_0002);
        bus_read(IRQ_STATUS_ADDR, 32'h0000_0000);
        `CHECK(rec_irq_n, 1'b1)
        bus_write(SUBBLOCK_RESET_ADDR, 32'h0000_0000);
        bus_read(REC_CURRENT_ADDR, 32'h0000_1000);
    endtask : test_record

    // reset for ten cycles, then the scenarios in turn
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {hsel, hwrite, adc_sel, run, slow} = 5'b00000;
        htrans = HTRANS_IDLE;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        test_reset_state();
        test_ctrl_fields();
        test_data_regs();
        test_record();
        test_done();
    end
endmodule : test_audio_path_reset_record_dma_regs

`default_nettype wire
